// file: scmc_clk_div.sv
`default_nettype none
module scmc_clk_div (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // fast tick in, divided tick out
  input wire logic tick,
  input wire logic [2:0] ratio_code,
  output logic pulse
);
  logic [5:0] cnt_reg;
  logic [6:0] one_hot;
  logic [5:0] mask;

  // code n passes one tick in 2**n; code 7 passes one in 64, as code 6 does
  assign one_hot = 7'h01 << ratio_code;
  assign mask = 6'(one_hot - 7'h01);
  assign pulse = tick & ((cnt_reg & mask) == mask);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= 6'h00;
    end else if (tick) begin
      cnt_reg <= cnt_reg + 6'h01;
    end
  end
endmodule
`default_nettype wire

// file: scmc_pkg.sv
`default_nettype none
package scmc_pkg;
  typedef enum logic [5:0] {
    SCMC_FAST = 6'h01,
    SCMC_SLOW = 6'h02,
    SCMC_SLEEP = 6'h04,
    SCMC_IDLE_LOW = 6'h08,
    SCMC_IDLE_BOTH = 6'h10,
    SCMC_IDLE_HIGH = 6'h20
  } scmc_mode_type;
  typedef enum logic [2:0] {
    SCMC_SW_IDLE = 3'h1,
    SCMC_SW_CUR = 3'h2,
    SCMC_SW_TGT = 3'h4
  } scmc_sw_type;
endpackage
`default_nettype wire

// file: scmc_regs.svh
// Contract
// - six modes: fast, slow, sleep, idle_low_only, idle_both, idle_high_only
// - cpu-off modes only on halt; keep-alive bits pick which one
// - sys_clk_select: 000 fast, 001..110 fast/2..fast/64, 111 slow
// - fast mode: cpu on divided fast_clk, fast and slow clocks run
// - hs_source_select 0 picks internal fast rc, 1 picks crystal
// - slow mode: system clock is slow_clk from int_slow_rc, cpu runs
// - slow mode: fast_clk follows enable bit of selected fast source
// - halt with both keep bits 0: sleep, every clock stops
// - int_slow_rc runs in sleep only with watchdog enabled, else always
// - idle_low_only: fast_clk off, slow on, sysclk only for code 111
// - idle_both: cpu off, system, fast and slow clocks all run
// - idle_high_only: slow off, fast on, sysclk only for 000..110
// - hs_osc_idle_keep 1 keeps fast oscillator running after halt
// - bits 4 and 2 of sys_clock_ctrl read as zero
// - ls_osc_idle_keep at bit 0 keeps slow oscillator after halt
// - switch waits four current ticks then a target tick
// - int_rc_stable clears on enable or freq change; freq applies after
// - crystal_stable clears on enable, sets when oscillator settles
`ifndef SCMC_REGS_SVH
`define SCMC_REGS_SVH
`define SCMC_OFS_SCC 8'h00
`define SCMC_OFS_RC 8'h04
`define SCMC_OFS_XT 8'h08
`define SCMC_SCC_SEL_MSB 7
`define SCMC_SCC_SEL_LSB 5
`define SCMC_SCC_SRC_BIT 3
`define SCMC_SCC_HSK_BIT 1
`define SCMC_SCC_LSK_BIT 0
`define SCMC_RC_FREQ_MSB 3
`define SCMC_RC_FREQ_LSB 2
`define SCMC_RC_STB_BIT 1
`define SCMC_RC_EN_BIT 0
`define SCMC_XT_DRV_BIT 2
`define SCMC_XT_STB_BIT 1
`define SCMC_XT_EN_BIT 0
`define SCMC_SCC_RST 8'h00
`define SCMC_RC_RST 8'h01
`define SCMC_XT_RST 8'h00
`define SCMC_SEL_SLOW 3'h7
`define SCMC_SW_CUR_TICKS 3'h4
`define SCMC_STAB_TICKS 8'h40
`endif

// file: scmc_top.sv
// Design decisions made here: the address map and the APB register port.
`default_nettype none
`include "scmc_regs.svh"
module scmc_top import scmc_pkg::*; (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // cpu and watchdog side
  input wire logic halt_req,
  input wire logic wake_req,
  input wire logic watchdog_enable,
  // raw oscillator waves
  input wire logic int_fast_rc_wave,
  input wire logic ext_crystal_wave,
  input wire logic int_slow_rc_wave,
  // oscillator run controls
  output logic int_fast_rc_run,
  output logic ext_crystal_run,
  output logic int_slow_rc_run,
  output logic [1:0] int_rc_freq_applied,
  // clock enables and status
  output logic sys_clk_en,
  output logic cpu_clk_en,
  output logic fast_clk_en,
  output logic slow_clk_en,
  output logic cpu_running,
  output logic [5:0] op_mode
);
  logic [2:0] sel_reg;
  logic src_reg;
  logic hs_keep_reg;
  logic ls_keep_reg;
  logic [1:0] rc_freq_reg;
  logic rc_en_reg;
  logic xt_drive_reg;
  logic xt_en_reg;
  logic [1:0] stable_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] rd_word;
  logic hit;
  logic setup;
  logic wr;
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic [2:0] sync3_reg;
  logic [2:0] wave_in;
  logic [2:0] tick;
  logic [1:0] osc_en;
  logic [1:0] en_q_reg;
  logic [1:0] freq_q_reg;
  logic [1:0] restart;
  logic [1:0] fast_run;
  logic [7:0] stab_cnt_reg [0:1];
  logic [2:0] sel_act_reg;
  logic src_act_reg;
  logic [2:0] sel_pend_reg;
  logic src_pend_reg;
  logic [2:0] sw_cnt_reg;
  scmc_sw_type sw_reg;
  scmc_mode_type mode_reg;
  scmc_mode_type run_mode;
  logic fast_tick;
  logic slow_tick;
  logic div_pulse;
  logic cur_tick;
  logic tgt_tick;
  logic act_slow;
  logic fast_allow;
  logic sel_force;
  logic pend_force;
  logic slow_allow;
  logic sys_on;
  logic cpu_on;
  logic sys_tick;
  logic rc_run_next;
  logic xt_run_next;
  logic [1:0] freq_applied_reg;
  logic rc_run_reg;
  logic xt_run_reg;
  logic slow_run_reg;
  logic sys_en_reg;
  logic cpu_en_reg;
  logic fast_en_reg;
  logic slow_en_reg;
  logic cpu_run_reg;
  localparam logic [7:0] scc_rst = `SCMC_SCC_RST;
  localparam logic [7:0] rc_rst = `SCMC_RC_RST;
  localparam logic [7:0] xt_rst = `SCMC_XT_RST;

  // apb: zero wait states, pready raised for the access cycle
  assign setup = psel & ~penable;
  assign wr = psel & penable & pready_reg & pwrite;
  assign hit = (paddr == `SCMC_OFS_SCC) | (paddr == `SCMC_OFS_RC) |
               (paddr == `SCMC_OFS_XT);

  always_comb begin
    rd_word = 32'h0000_0000;
    case (paddr)
      `SCMC_OFS_SCC: begin
        rd_word[`SCMC_SCC_SEL_MSB:`SCMC_SCC_SEL_LSB] = sel_reg;
        rd_word[`SCMC_SCC_SRC_BIT] = src_reg;
        rd_word[`SCMC_SCC_HSK_BIT] = hs_keep_reg;
        rd_word[`SCMC_SCC_LSK_BIT] = ls_keep_reg;
      end
      `SCMC_OFS_RC: begin
        rd_word[`SCMC_RC_FREQ_MSB:`SCMC_RC_FREQ_LSB] = rc_freq_reg;
        rd_word[`SCMC_RC_STB_BIT] = stable_reg[0];
        rd_word[`SCMC_RC_EN_BIT] = rc_en_reg;
      end
      `SCMC_OFS_XT: begin
        rd_word[`SCMC_XT_DRV_BIT] = xt_drive_reg;
        rd_word[`SCMC_XT_STB_BIT] = stable_reg[1];
        rd_word[`SCMC_XT_EN_BIT] = xt_en_reg;
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      pready_reg <= setup;
      pslverr_reg <= setup & ~hit;
      if (setup) begin
        prdata_reg <= rd_word;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sel_reg <= scc_rst[`SCMC_SCC_SEL_MSB:`SCMC_SCC_SEL_LSB];
      src_reg <= scc_rst[`SCMC_SCC_SRC_BIT];
      hs_keep_reg <= scc_rst[`SCMC_SCC_HSK_BIT];
      ls_keep_reg <= scc_rst[`SCMC_SCC_LSK_BIT];
    end else if (wr && paddr == `SCMC_OFS_SCC) begin
      sel_reg <= pwdata[`SCMC_SCC_SEL_MSB:`SCMC_SCC_SEL_LSB];
      src_reg <= pwdata[`SCMC_SCC_SRC_BIT];
      hs_keep_reg <= pwdata[`SCMC_SCC_HSK_BIT];
      ls_keep_reg <= pwdata[`SCMC_SCC_LSK_BIT];
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rc_freq_reg <= rc_rst[`SCMC_RC_FREQ_MSB:`SCMC_RC_FREQ_LSB];
      rc_en_reg <= rc_rst[`SCMC_RC_EN_BIT];
    end else if (wr && paddr == `SCMC_OFS_RC) begin
      rc_freq_reg <= pwdata[`SCMC_RC_FREQ_MSB:`SCMC_RC_FREQ_LSB];
      rc_en_reg <= pwdata[`SCMC_RC_EN_BIT];
    end
  end

  // drive mode is frozen while the crystal is enabled
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      xt_drive_reg <= xt_rst[`SCMC_XT_DRV_BIT];
      xt_en_reg <= xt_rst[`SCMC_XT_EN_BIT];
    end else if (wr && paddr == `SCMC_OFS_XT) begin
      if (!xt_en_reg) begin
        xt_drive_reg <= pwdata[`SCMC_XT_DRV_BIT];
      end
      xt_en_reg <= pwdata[`SCMC_XT_EN_BIT];
    end
  end

  // oscillator waves are asynchronous; edge found after two flops
  assign wave_in = {int_slow_rc_wave, ext_crystal_wave, int_fast_rc_wave};
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
          sync3_reg[gi] <= 1'b0;
        end else begin
          sync1_reg[gi] <= wave_in[gi];
          sync2_reg[gi] <= sync1_reg[gi];
          sync3_reg[gi] <= sync2_reg[gi];
        end
      end
      assign tick[gi] = sync2_reg[gi] & ~sync3_reg[gi];
    end
  endgenerate

  // stability tracking: restart on enable rise or rc freq change
  assign osc_en = {xt_en_reg, rc_en_reg};
  assign fast_run = {xt_run_reg, rc_run_reg};
  assign restart[0] = rc_en_reg & (~en_q_reg[0] |
                      (rc_freq_reg != freq_q_reg));
  assign restart[1] = xt_en_reg & ~en_q_reg[1];

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      en_q_reg <= 2'h0;
      freq_q_reg <= 2'h0;
    end else begin
      en_q_reg <= osc_en;
      freq_q_reg <= rc_freq_reg;
    end
  end

  generate
    for (gi = 0; gi < 2; gi++) begin : g_stab
      always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          stab_cnt_reg[gi] <= 8'h00;
          stable_reg[gi] <= 1'b0;
        end else if (!fast_run[gi] || restart[gi]) begin
          stab_cnt_reg[gi] <= 8'h00;
          stable_reg[gi] <= 1'b0;
        end else if (tick[gi] && !stable_reg[gi]) begin
          stab_cnt_reg[gi] <= stab_cnt_reg[gi] + 8'h01;
          if (stab_cnt_reg[gi] == `SCMC_STAB_TICKS - 8'h01) begin
            stable_reg[gi] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  // rc frequency takes effect only once the oscillator is stable
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      freq_applied_reg <= rc_rst[`SCMC_RC_FREQ_MSB:`SCMC_RC_FREQ_LSB];
    end else if (stable_reg[0] && !restart[0]) begin
      freq_applied_reg <= rc_freq_reg;
    end
  end

  // fast_clk follows the active source, gated by its run control
  assign fast_tick = src_act_reg ? (tick[1] & xt_run_reg) :
                     (tick[0] & rc_run_reg);
  assign slow_allow = (mode_reg != SCMC_SLEEP) &&
                      (mode_reg != SCMC_IDLE_HIGH);
  assign slow_tick = tick[2] & slow_allow;

  scmc_clk_div u_div (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .tick(fast_tick),
    .ratio_code(sel_act_reg),
    .pulse(div_pulse)
  );

  assign act_slow = (sel_act_reg == `SCMC_SEL_SLOW);
  assign sys_tick = act_slow ? slow_tick : div_pulse;
  assign cur_tick = sys_tick;
  // fast target edge only from a source that runs and is stable; a slow target takes any slow_tick
  assign tgt_tick = (sel_pend_reg == `SCMC_SEL_SLOW) ? slow_tick :
                    (src_pend_reg ? (tick[1] & stable_reg[1]) :
                     (tick[0] & stable_reg[0]));

  // switch waits four current ticks then lands on a target edge
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sw_reg <= SCMC_SW_IDLE;
      sw_cnt_reg <= 3'h0;
      sel_act_reg <= scc_rst[`SCMC_SCC_SEL_MSB:`SCMC_SCC_SEL_LSB];
      src_act_reg <= scc_rst[`SCMC_SCC_SRC_BIT];
      sel_pend_reg <= 3'h0;
      src_pend_reg <= 1'b0;
    end else begin
      case (sw_reg)
        SCMC_SW_IDLE: begin
          if ({src_reg, sel_reg} != {src_act_reg, sel_act_reg}) begin
            sel_pend_reg <= sel_reg;
            src_pend_reg <= src_reg;
            sw_cnt_reg <= 3'h0;
            sw_reg <= SCMC_SW_CUR;
          end
        end
        SCMC_SW_CUR: begin
          if (cur_tick) begin
            sw_cnt_reg <= sw_cnt_reg + 3'h1;
            if (sw_cnt_reg == `SCMC_SW_CUR_TICKS - 3'h1) begin
              sw_reg <= SCMC_SW_TGT;
            end
          end
        end
        SCMC_SW_TGT: begin
          if (tgt_tick) begin
            sel_act_reg <= sel_pend_reg;
            src_act_reg <= src_pend_reg;
            sw_reg <= SCMC_SW_IDLE;
          end
        end
        default: begin
          sw_reg <= SCMC_SW_IDLE;
        end
      endcase
    end
  end

  // operating mode; halt picks the cpu-off mode from keep bits
  assign run_mode = act_slow ? SCMC_SLOW : SCMC_FAST;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      mode_reg <= SCMC_FAST;
    end else begin
      case (mode_reg)
        SCMC_FAST, SCMC_SLOW: begin
          if (halt_req) begin
            case ({hs_keep_reg, ls_keep_reg})
              2'h0: mode_reg <= SCMC_SLEEP;
              2'h1: mode_reg <= SCMC_IDLE_LOW;
              2'h3: mode_reg <= SCMC_IDLE_BOTH;
              default: mode_reg <= SCMC_IDLE_HIGH;
            endcase
          end else begin
            mode_reg <= run_mode;
          end
        end
        SCMC_SLEEP, SCMC_IDLE_LOW, SCMC_IDLE_BOTH, SCMC_IDLE_HIGH: begin
          if (wake_req) begin
            mode_reg <= run_mode;
          end
        end
        default: begin
          mode_reg <= SCMC_FAST;
        end
      endcase
    end
  end

  // registered twin of the cpu-on decode; follows the mode transitions
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cpu_run_reg <= 1'b1;
    end else if (cpu_run_reg && halt_req) begin
      cpu_run_reg <= 1'b0;
    end else if (!cpu_run_reg && wake_req) begin
      cpu_run_reg <= 1'b1;
    end
  end

  // oscillator and clock gating per mode
  assign fast_allow = (mode_reg == SCMC_FAST) || (mode_reg == SCMC_SLOW) ||
                      (mode_reg == SCMC_IDLE_BOTH) ||
                      (mode_reg == SCMC_IDLE_HIGH);
  assign sel_force = (mode_reg != SCMC_SLOW) && fast_allow;
  // a pending fast target is forced on so the switch cannot hang
  assign pend_force = (sw_reg != SCMC_SW_IDLE) &&
                      (sel_pend_reg != `SCMC_SEL_SLOW);
  assign rc_run_next = fast_allow & (rc_en_reg |
                       (sel_force & ~src_act_reg) |
                       (pend_force & ~src_pend_reg));
  assign xt_run_next = fast_allow & (xt_en_reg |
                       (sel_force & src_act_reg) |
                       (pend_force & src_pend_reg));
  assign cpu_on = (mode_reg == SCMC_FAST) || (mode_reg == SCMC_SLOW);

  always_comb begin
    case (mode_reg)
      SCMC_FAST, SCMC_SLOW, SCMC_IDLE_BOTH: sys_on = 1'b1;
      SCMC_IDLE_LOW: sys_on = act_slow;
      SCMC_IDLE_HIGH: sys_on = ~act_slow;
      default: sys_on = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rc_run_reg <= 1'b0;
      xt_run_reg <= 1'b0;
      slow_run_reg <= 1'b0;
    end else begin
      rc_run_reg <= rc_run_next;
      xt_run_reg <= xt_run_next;
      slow_run_reg <= (mode_reg != SCMC_SLEEP) | watchdog_enable;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sys_en_reg <= 1'b0;
      cpu_en_reg <= 1'b0;
      fast_en_reg <= 1'b0;
      slow_en_reg <= 1'b0;
    end else begin
      sys_en_reg <= sys_tick & sys_on;
      cpu_en_reg <= sys_tick & cpu_on;
      fast_en_reg <= fast_tick & fast_allow;
      slow_en_reg <= slow_tick;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign int_fast_rc_run = rc_run_reg;
  assign ext_crystal_run = xt_run_reg;
  assign int_slow_rc_run = slow_run_reg;
  assign int_rc_freq_applied = freq_applied_reg;
  assign sys_clk_en = sys_en_reg;
  assign cpu_clk_en = cpu_en_reg;
  assign fast_clk_en = fast_en_reg;
  assign slow_clk_en = slow_en_reg;
  assign cpu_running = cpu_run_reg;
  assign op_mode = mode_reg;
endmodule
`default_nettype wire

// file: scmc_top_assertions.sv
`default_nettype none
module scmc_top_assertions import scmc_pkg::*; (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // apb handshake
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // cpu side
  input wire logic halt_req,
  input wire logic watchdog_enable,
  // clocks and status
  input wire logic int_slow_rc_run,
  input wire logic sys_clk_en,
  input wire logic cpu_clk_en,
  input wire logic fast_clk_en,
  input wire logic slow_clk_en,
  input wire logic cpu_running,
  input wire logic [5:0] op_mode
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // run outputs lag the mode flop by one edge, hence the [*2] guards
  mode_onehot_a:
    assert property ($onehot(op_mode)) else $error("mode not one-hot");
  run_decode_a:
    assert property (cpu_running == (op_mode inside {SCMC_FAST, SCMC_SLOW}))
    else $error("cpu_running wrong for mode");
  halt_only_a:
    assert property (cpu_running && !halt_req |=> cpu_running)
    else $error("cpu stopped without halt");
  cpu_gated_a:
    assert property (cpu_clk_en |-> $past(cpu_running))
    else $error("cpu tick while halted");
  sleep_quiet_a:
    assert property ((op_mode == SCMC_SLEEP)[*2] |->
      !(sys_clk_en || fast_clk_en || slow_clk_en)) else $error("tick in sleep");
  sleep_wdog_a:
    assert property ((op_mode == SCMC_SLEEP)[*2] |->
      int_slow_rc_run == $past(watchdog_enable)) else $error("slow rc in sleep");
  idle_low_a:
    assert property ((op_mode == SCMC_IDLE_LOW)[*2] |->
      !fast_clk_en && int_slow_rc_run) else $error("idle_low clocks");
  idle_both_a:
    assert property ((op_mode == SCMC_IDLE_BOTH)[*2] |-> int_slow_rc_run)
    else $error("idle_both slow rc off");
  idle_high_a:
    assert property ((op_mode == SCMC_IDLE_HIGH)[*2] |-> !slow_clk_en)
    else $error("idle_high slow tick");
  run_slow_osc_a:
    assert property (cpu_running[*3] |-> int_slow_rc_run)
    else $error("slow rc off while running");
  apb_zero_wait_a:
    assert property (psel && !penable |=> pready) else $error("no ready");
  ready_pulse_a:
    assert property (pready |=> !pready) else $error("ready held");
  err_with_ready_a:
    assert property (pslverr |-> pready) else $error("error without ready");
endmodule
bind scmc_top scmc_top_assertions scmc_top_assertions_inst (
  .clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .halt_req(halt_req),
  .watchdog_enable(watchdog_enable), .int_slow_rc_run(int_slow_rc_run),
  .sys_clk_en(sys_clk_en), .cpu_clk_en(cpu_clk_en),
  .fast_clk_en(fast_clk_en), .slow_clk_en(slow_clk_en),
  .cpu_running(cpu_running), .op_mode(op_mode)
);
`default_nettype wire

// file: system_clock_mode_control_test.sv
`default_nettype none
module system_clock_mode_control_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys, nrst, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic halt_req, wake_req, watchdog_enable, e;
  logic int_fast_rc_wave, ext_crystal_wave, int_slow_rc_wave;
  logic int_fast_rc_run, ext_crystal_run, int_slow_rc_run;
  logic [1:0] int_rc_freq_applied;
  logic sys_clk_en, cpu_clk_en, fast_clk_en, slow_clk_en, cpu_running;
  logic [5:0] op_mode;
  int error_cnt, checks_done;
  integer ns, nf, nl, nc;
  int unsigned tcnt = 0;
  logic [1:0] keep_t [5] = '{2'h0, 2'h1, 2'h3, 2'h2, 2'h0};
  logic [5:0] mode_t [5] = '{6'h04, 6'h08, 6'h10, 6'h20, 6'h04};
  scmc_top scmc_top_inst (.*);
  always #12.5 clk_sys = ~clk_sys;
  // oscillators stand low while their run request is off
  always @(posedge clk_sys) begin
    tcnt <= tcnt + 1;
    int_fast_rc_wave <= int_fast_rc_run & tcnt[2];
    ext_crystal_wave <= ext_crystal_run & (tcnt % 10 < 5);
    int_slow_rc_wave <= int_slow_rc_run & (tcnt % 24 < 12);
  end
  task automatic conclude;
    $display("checks=%0d errors=%0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // window edges may cut one tick either way
  task automatic near(input integer got, exp);
    checks_done++;
    if ((got <= exp + 1 && got >= exp - 1) !== 1'b1) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    // one idle edge so a following call never retoggles psel at once
    @(posedge clk_sys);
  endtask
  task automatic tally(input int n);
    {ns, nf, nl, nc} = 0;
    repeat (n) begin
      @(posedge clk_sys);
      #1;
      ns += sys_clk_en;
      nf += fast_clk_en;
      nl += slow_clk_en;
      nc += cpu_clk_en;
    end
  endtask
  task automatic wait_stable(input logic [7:0] a);
    r = 0;
    repeat (100) if (!r[1]) begin
      repeat (20) @(posedge clk_sys);
      xfer(0, a, 0);
    end
    chk(r[1], 1);
  endtask
  initial begin
    repeat (80000) @(posedge clk_sys);
    error_cnt++;
    conclude;
  end
  initial begin
    {clk_sys, nrst, psel, penable, pwrite, halt_req, wake_req} = 0;
    {paddr, pwdata, watchdog_enable} = 0;
    repeat (3) @(posedge clk_sys);
    nrst <= 1;
    @(posedge clk_sys);
    xfer(0, 8'h00, 0);
    chk(r, 32'h0);
    xfer(0, 8'h04, 0);
    chk(r & ~32'h2, 32'h1);
    xfer(0, 8'h08, 0);
    chk(r, 32'h0);
    // unmapped word answers with an error and zero data
    xfer(0, 8'h0c, 0);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0);
    xfer(1, 8'h00, 32'h17);
    xfer(0, 8'h00, 0);
    chk(r, 32'h3);
    $display("test registers done");
    for (int i = 0; i < 5; i++) begin
      xfer(1, 8'h00, {30'h0, keep_t[i]});
      watchdog_enable <= (i == 4);
      halt_req <= 1;
      @(posedge clk_sys);
      halt_req <= 0;
      tally(100);
      chk(op_mode, mode_t[i]);
      chk(cpu_running, 0);
      chk(nc, 0);
      chk(int_slow_rc_run, i != 0);
      chk(nf != 0, keep_t[i][1]);
      chk(nl != 0, keep_t[i][0]);
      chk(ns != 0, keep_t[i][1]);
      wake_req <= 1;
      @(posedge clk_sys);
      wake_req <= 0;
      @(posedge clk_sys);
      chk(op_mode, 6'h01);
      wait_stable(8'h04);
    end
    $display("test halt modes done");
    for (int c = 0; c < 8; c++) begin
      xfer(1, 8'h00, {24'h0, c[2:0], 5'h0});
      repeat (64 << c) @(posedge clk_sys);
      tally(2048);
      if (c < 7) begin
        near(ns, nf >> c);
      end else begin
        near(ns, nl);
      end
      chk(nc, ns);
      chk(nl != 0, 1);
    end
    chk(nf != 0, 1);
    // halts taken while the slow clock drives the system
    for (int k = 1; k < 3; k++) begin
      xfer(1, 8'h00, {24'h0, 3'h7, 3'h0, k[1:0]});
      halt_req <= 1;
      @(posedge clk_sys);
      halt_req <= 0;
      tally(100);
      chk(op_mode, (k == 1) ? 6'h08 : 6'h20);
      chk(ns != 0, k == 1);
      wake_req <= 1;
      @(posedge clk_sys);
      wake_req <= 0;
      @(posedge clk_sys);
      chk(op_mode, 6'h02);
    end
    xfer(1, 8'h04, 32'h0);
    tally(200);
    chk(nf, 0);
    chk(int_fast_rc_run, 0);
    xfer(1, 8'h04, 32'h5);
    xfer(0, 8'h04, 0);
    chk(r[1], 0);
    chk(int_rc_freq_applied, 0);
    wait_stable(8'h04);
    chk(int_rc_freq_applied, 1);
    $display("test divider and slow mode done");
    xfer(1, 8'h08, 32'h1);
    xfer(0, 8'h08, 0);
    chk(r[1], 0);
    wait_stable(8'h08);
    // drive mode must not change while the crystal is enabled
    xfer(1, 8'h08, 32'h5);
    xfer(0, 8'h08, 0);
    chk(r, 32'h3);
    xfer(1, 8'h00, 32'h8);
    repeat (2000) @(posedge clk_sys);
    tally(500);
    chk(ext_crystal_run, 1);
    near(nf, 50);
    near(ns, nf);
    $display("test crystal source done");
    conclude;
  end
endmodule
`default_nettype wire
